// [rtl/rio_top.sv]
`timescale 1ns/10ps
module rio_top import rio_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// host request
	input wire rio_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// strobed-mode control
	input wire logic strobe_mode,
	input wire logic strobe_out_dir,
	input wire logic irq_enable,
	input wire logic strobe_in_n,
	output logic ack_out_n,
	output logic transfer_interrupt,
	// port pins
	input wire logic [7:0] pa_in,
	output logic [7:0] pa_out,
	output logic [7:0] pa_oe_n,
	input wire logic [7:0] pb_in,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe_n
);
	logic [7:0] mem [RIO_MEM_DEPTH];
	logic [7:0] dir_a_r, dir_b_r, out_a_r, out_b_r, latch_a_r;
	logic strobe_d_r, done_r;
	logic [7:0] pin_a, pin_b;
	logic [7:0] sel_out, sel_dir, sel_pin;
	logic [2:0] bit_idx;
	logic strobe_fall, host_a_access;

	// pin value as seen by the host: own driver for outputs, pin for inputs
	function automatic logic [7:0] seen(input logic [7:0] dir, input logic [7:0] o,
			input logic [7:0] i);
		seen = (dir & o) | (~dir & i);
	endfunction

	assign bit_idx = req.addr[2:0];
	assign pin_a = seen(dir_a_r, out_a_r, pa_in);
	assign pin_b = seen(dir_b_r, out_b_r, pb_in);
	assign sel_out = req.port_sel ? out_b_r : out_a_r;
	assign sel_dir = req.port_sel ? dir_b_r : dir_a_r;
	// strobed input reads see the captured byte, not live pins
	assign sel_pin = req.port_sel ? pin_b :
		((strobe_mode && !strobe_out_dir) ? latch_a_r : pin_a);
	assign strobe_fall = strobe_d_r & ~strobe_in_n;
	assign host_a_access = req.valid && !req.port_sel &&
		(req.op == RIO_OP_PORT_RD || req.op == RIO_OP_PORT_WR);

	// memory touches only its own array
	always_ff @(posedge clk) begin
		if (req.valid && req.op == RIO_OP_MEM_WR) begin
			mem[req.addr] <= req.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dir_a_r <= RIO_DIR_RST;
			dir_b_r <= RIO_DIR_RST;
		end else if (req.valid && req.op == RIO_OP_DIR_WR) begin
			if (req.port_sel) dir_b_r <= req.wdata;
			else dir_a_r <= req.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_a_r <= RIO_OUT_RST;
			out_b_r <= RIO_OUT_RST;
		end else if (req.valid) begin
			case (req.op)
				RIO_OP_PORT_WR: begin
					if (req.port_sel) out_b_r <= req.wdata;
					else out_a_r <= req.wdata;
				end
				RIO_OP_BIT_SET: begin
					if (req.port_sel) out_b_r[bit_idx] <= 1'b1;
					else out_a_r[bit_idx] <= 1'b1;
				end
				RIO_OP_BIT_CLR: begin
					if (req.port_sel) out_b_r[bit_idx] <= 1'b0;
					else out_a_r[bit_idx] <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.valid && (req.op == RIO_OP_MEM_RD || req.op == RIO_OP_PORT_RD);
			if (req.valid && req.op == RIO_OP_MEM_RD) begin
				rdata <= mem[req.addr];
			end else if (req.valid && req.op == RIO_OP_PORT_RD) begin
				// bit read returns the chosen bit in bit 0
				if (req.bit_rd) rdata <= {7'h00, sel_pin[bit_idx]};
				else rdata <= sel_pin;
			end
		end
	end

	// strobed handshake on port a only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			strobe_d_r <= 1'b1;
			latch_a_r <= 8'h00;
			ack_out_n <= 1'b1;
			done_r <= 1'b0;
		end else begin
			strobe_d_r <= strobe_in_n;
			if (!strobe_mode) begin
				ack_out_n <= 1'b1;
				done_r <= 1'b0;
			end else begin
				if (strobe_fall && !strobe_out_dir) latch_a_r <= pa_in;
				// set wins over the host access that clears it
				if (strobe_fall) done_r <= 1'b1;
				else if (host_a_access) done_r <= 1'b0;
				// output direction: tell the peripheral new data is ready
				if (strobe_out_dir && host_a_access && req.op == RIO_OP_PORT_WR) ack_out_n <= 1'b0;
				else if (strobe_fall) ack_out_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) transfer_interrupt <= 1'b0;
		else transfer_interrupt <= strobe_mode && irq_enable && (done_r || strobe_fall);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pa_out <= RIO_OUT_RST;
			pb_out <= RIO_OUT_RST;
			pa_oe_n <= RIO_OE_N_RST;
			pb_oe_n <= RIO_OE_N_RST;
		end else begin
			pa_out <= out_a_r;
			pb_out <= out_b_r;
			pa_oe_n <= ~dir_a_r;
			pb_oe_n <= ~dir_b_r;
		end
	end

	// a full reset must release every pin
	rst_release_a: assert property (@(posedge clk)
		sys_rst |=> (pa_oe_n == 8'hff && pb_oe_n == 8'hff))
		else $error("pins driven after reset");
	no_irq_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		!strobe_mode ##1 !strobe_mode |-> !transfer_interrupt)
		else $error("interrupt outside strobed mode");
	irq_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
		!irq_enable |=> !transfer_interrupt)
		else $error("interrupt while disabled");
	oe_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.valid && req.op == RIO_OP_DIR_WR && req.port_sel
		|=> ##1 pb_oe_n == ~$past(req.wdata, 2))
		else $error("direction not applied");
	bit_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.valid && req.op == RIO_OP_BIT_SET && !req.port_sel |=> out_a_r[$past(bit_idx)])
		else $error("bit set lost");
	bit_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.valid && req.op == RIO_OP_BIT_CLR && req.port_sel |=> !out_b_r[$past(bit_idx)])
		else $error("bit clear lost");
	mem_iso_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.valid && (req.op == RIO_OP_MEM_WR || req.op == RIO_OP_MEM_RD)
		|=> $stable(out_a_r) && $stable(dir_a_r))
		else $error("memory access touched port");
	rd_resp_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.valid && req.op == RIO_OP_PORT_RD |=> rvalid)
		else $error("read without answer");

	// handshake steps shared by the strobe checks
	sequence strobe_done_s;
		strobe_mode && strobe_fall;
	endsequence
	sequence irq_armed_s;
		strobe_done_s ##0 irq_enable;
	endsequence
	sequence out_write_s;
		strobe_mode && strobe_out_dir && host_a_access && req.op == RIO_OP_PORT_WR;
	endsequence
	sequence in_capture_s;
		strobe_done_s ##0 !strobe_out_dir;
	endsequence

	irq_raise_a: assert property (@(posedge clk) disable iff (sys_rst)
		irq_armed_s |=> transfer_interrupt)
		else $error("completed transfer gave no interrupt");
	ack_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
		out_write_s |=> !ack_out_n)
		else $error("ready not signalled after write");
	ack_release_a: assert property (@(posedge clk) disable iff (sys_rst)
		strobe_done_s ##0 !host_a_access |=> ack_out_n)
		else $error("ready kept after strobe");
	ack_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		!strobe_mode |=> ack_out_n)
		else $error("ready outside strobed mode");
	in_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
		in_capture_s |=> latch_a_r == $past(pa_in))
		else $error("strobed input not captured");
	pb_steady_a: assert property (@(posedge clk) disable iff (sys_rst)
		strobe_done_s ##0 !req.valid |=> $stable(out_b_r) && $stable(dir_b_r))
		else $error("strobe disturbed port b");
	// output bits read back the driver, not the pin, except port a in strobed input mode, which reads the captured byte
	own_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.valid && req.op == RIO_OP_PORT_RD && req.bit_rd && sel_dir[bit_idx] &&
		(req.port_sel || !strobe_mode) |=> rdata[0] == $past(sel_out[bit_idx]))
		else $error("output bit read wrong");
endmodule

// [rtl/rio_pkg.sv]
package rio_pkg;
	localparam int RIO_MEM_DEPTH = 128;
	localparam int RIO_ADDR_W = 7;
	localparam int RIO_DATA_W = 8;
	// host operation codes
	typedef enum logic [2:0] {
		RIO_OP_IDLE,
		RIO_OP_MEM_WR,
		RIO_OP_MEM_RD,
		RIO_OP_PORT_WR,
		RIO_OP_PORT_RD,
		RIO_OP_DIR_WR,
		RIO_OP_BIT_SET,
		RIO_OP_BIT_CLR
	} rio_op_t;
	localparam logic [2:0] RIO_OP_BIT_RD = 3'h0;
	// request bundle from the host
	typedef struct packed {
		logic valid;
		rio_op_t op;
		logic bit_rd;
		logic port_sel;
		logic [6:0] addr;
		logic [7:0] wdata;
	} rio_req_t;
	localparam logic [7:0] RIO_DIR_RST = 8'h00;
	localparam logic [7:0] RIO_OUT_RST = 8'h00;
	localparam logic [7:0] RIO_OE_N_RST = 8'hff;
endpackage

// [tb/rio_periph.sv]
`timescale 1ns/10ps
module rio_periph (
	// bench control
	input wire logic clk,
	input wire logic [7:0] drv_a,
	input wire logic [7:0] drv_b,
	input wire logic pulse,
	// device pins
	input wire logic [7:0] pa_out,
	input wire logic [7:0] pa_oe_n,
	input wire logic [7:0] pb_out,
	input wire logic [7:0] pb_oe_n,
	output logic [7:0] pa_in,
	output logic [7:0] pb_in,
	output logic strobe_in_n
);
	// a released pin shows the peripheral's level, a driven one the device's
	assign pa_in = (pa_oe_n & drv_a) | (~pa_oe_n & pa_out);
	assign pb_in = (pb_oe_n & drv_b) | (~pb_oe_n & pb_out);
	initial strobe_in_n = 1'b1;
	always @(posedge clk) strobe_in_n <= ~pulse;
endmodule

// [tb/test_ram_with_two_io_ports.sv]
`timescale 1ns/10ps
module test_ram_with_two_io_ports import rio_pkg::*; ;
	logic clk = 0, sys_rst = 1, sm = 0, sd = 0, ie = 0, pulse = 0, rvalid, ack_n, ti, sin_n;
	logic [7:0] ea = 0, eb = 0, rdata, pa_out, pa_oe_n, pb_out, pb_oe_n, pa_in, pb_in, x, e;
	logic [7:0] md [4];
	logic [6:0] ma [4];
	rio_req_t req = '0;
	int bad_count = 0, checks = 0;
	logic [31:0] s = 15178;
	rio_top u_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .rvalid(rvalid),
		.strobe_mode(sm), .strobe_out_dir(sd), .irq_enable(ie), .strobe_in_n(sin_n),
		.ack_out_n(ack_n), .transfer_interrupt(ti), .pa_in(pa_in), .pa_out(pa_out),
		.pa_oe_n(pa_oe_n), .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n));
	rio_periph u_per (.clk(clk), .drv_a(ea), .drv_b(eb), .pulse(pulse), .pa_out(pa_out),
		.pa_oe_n(pa_oe_n), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pa_in(pa_in), .pb_in(pb_in),
		.strobe_in_n(sin_n));
	initial forever #10 clk = ~clk;
	function automatic logic [7:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s[7:0];
	endfunction
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one request; for reads waits, bounded, for the answer
	task automatic op(input rio_op_t o, input logic p, input logic b, input logic [6:0] a,
		input logic [7:0] d);
		int n;
		@(posedge clk) req <= '{1'b1, o, b, p, a, d};
		@(posedge clk) req.valid <= 1'b0;
		#1;
		if (o == RIO_OP_MEM_RD || o == RIO_OP_PORT_RD) begin
			for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(posedge clk) #1;
			if (n == 4) begin
				bad_count++;
				complete_run();
			end
		end else repeat (2) @(posedge clk) #1;
	endtask
	task automatic strobe();
		@(posedge clk) pulse <= 1'b1;
		@(posedge clk) pulse <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		cmp(pa_oe_n & pb_oe_n, 8'hff);
		cmp_bit(ti, 1'b0);
		cmp_bit(ack_n, 1'b1);
		for (int i = 0; i < 4; i++) begin
			ma[i] = 7'(i * 32) | 7'(rnd() & 8'h1f);
			md[i] = rnd();
			op(RIO_OP_MEM_WR, 0, 0, ma[i], md[i]);
		end
		for (int p = 0; p < 2; p++) begin
			x = rnd();
			e = rnd();
			@(posedge clk);
			eb <= e;
			ea <= e;
			op(RIO_OP_DIR_WR, p[0], 0, 0, 8'h0f);
			op(RIO_OP_PORT_WR, p[0], 0, 0, x);
			cmp(p ? pb_oe_n : pa_oe_n, 8'hf0);
			cmp((p ? pb_out : pa_out) & 8'h0f, x & 8'h0f);
			op(RIO_OP_BIT_CLR, p[0], 0, 7'h02, 8'h00);
			op(RIO_OP_BIT_SET, p[0], 0, 7'h01, 8'h00);
			e = (x & 8'h09) | 8'h02;
			cmp((p ? pb_out : pa_out) & 8'h0f, e);
			op(RIO_OP_PORT_RD, p[0], 1, 7'h06, 8'h00);
			cmp_bit(rdata[0], eb[6]);
			op(RIO_OP_PORT_RD, p[0], 1, 7'h01, 8'h00);
			cmp_bit(rdata[0], 1'b1);
			op(RIO_OP_PORT_RD, p[0], 0, 0, 8'h00);
			cmp(rdata, (eb & 8'hf0) | e);
			$display("port %0d test done", p);
		end
		for (int i = 0; i < 4; i++) begin
			op(RIO_OP_MEM_RD, 0, 0, ma[i], 8'h00);
			cmp(rdata, md[i]);
		end
		op(RIO_OP_DIR_WR, 0, 0, 0, 8'h00);
		x = rnd();
		@(posedge clk);
		sm <= 1'b1;
		ie <= 1'b1;
		ea <= x;
		strobe();
		cmp_bit(ti, 1'b1);
		@(posedge clk);
		ea <= ~x;
		op(RIO_OP_PORT_RD, 0, 0, 0, 8'h00);
		cmp(rdata, x);
		repeat (3) @(posedge clk) #1;
		cmp_bit(ti, 1'b0);
		@(posedge clk);
		ie <= 1'b0;
		strobe();
		cmp_bit(ti, 1'b0);
		op(RIO_OP_PORT_RD, 0, 0, 0, 8'h00);
		cmp(rdata, ~x);
		@(posedge clk);
		ie <= 1'b1;
		sm <= 1'b0;
		strobe();
		cmp_bit(ti, 1'b0);
		// strobed output: a host write raises ready, the strobe takes it back
		op(RIO_OP_DIR_WR, 0, 0, 0, 8'hff);
		@(posedge clk);
		sm <= 1'b1;
		sd <= 1'b1;
		x = rnd();
		op(RIO_OP_PORT_WR, 0, 0, 0, x);
		cmp_bit(ack_n, 1'b0);
		cmp_bit(ti, 1'b0);
		cmp(pa_out, x);
		strobe();
		cmp_bit(ack_n, 1'b1);
		cmp_bit(ti, 1'b1);
		op(RIO_OP_PORT_RD, 0, 0, 0, 8'h00);
		cmp(rdata, x);
		$display("strobe test done");
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		cmp(pa_oe_n & pb_oe_n, 8'hff);
		cmp_bit(ti, 1'b0);
		cmp_bit(ack_n, 1'b1);
		$display("reset test done");
		complete_run();
	end
endmodule
